//--- pkg/emc_pkg.sv
/*
 Package for the Ethernet MAC control block: register offsets, field positions,
 reset values and common types.
 Assumes a 32-bit AHB-Lite slave port with word-aligned registers.
*/
package emc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_TXCTL = 8'h00;
	localparam logic [7:0] OFF_RXCTL = 8'h04;
	localparam logic [7:0] OFF_TSCTL = 8'h08;
	localparam logic [7:0] OFF_ENCTL = 8'h0C;
	localparam logic [7:0] OFF_ADDRLO = 8'h10;
	localparam logic [7:0] OFF_ADDRHI = 8'h14;
	localparam logic [7:0] OFF_IRQRAW = 8'h18;
	localparam logic [7:0] OFF_IRQEN = 8'h1C;
	localparam logic [7:0] OFF_IRQMSK = 8'h20;
	localparam logic [7:0] OFF_MGMT = 8'h24;
	localparam logic [7:0] OFF_MGMTDAT = 8'h28;
	localparam logic [7:0] OFF_STATUS = 8'h2C;
	// Field positions
	localparam int TX_DUPLEX_BIT = 0;
	localparam int TX_FCS_BIT = 1;
	localparam int TX_PAD_BIT = 2;
	localparam int RX_BADFCS_BIT = 0;
	localparam int RX_PROMISC_BIT = 1;
	localparam int RX_MCAST_BIT = 2;
	localparam int TS_ROUTE_BIT = 0;
	localparam int EN_BIT = 0;
	localparam int MGMT_WRITE_BIT = 5;
	localparam int MGMT_BUSY_BIT = 6;
	localparam int ST_SPACE_BIT = 0;
	localparam int ST_PKT_BIT = 1;
	localparam int ST_EN_BIT = 2;
	// Interrupt source positions
	localparam int IRQ_RX = 0;
	localparam int IRQ_TXER = 1;
	localparam int IRQ_TX = 2;
	localparam int IRQ_RXOF = 3;
	localparam int IRQ_RXER = 4;
	localparam int IRQ_MGMT = 5;
	localparam int IRQ_PHY = 6;
	localparam int IRQ_W = 7;
	// Reset values
	localparam logic [2:0] TXCTL_RST = 3'h0;
	localparam logic [2:0] RXCTL_RST = 3'h0;
	localparam logic [47:0] ADDR_RST = 48'h0000_0000_0000;
	localparam logic [IRQ_W-1:0] IRQ_RST = 7'h00;
	// Frame lengths
	localparam logic [10:0] MIN_FRAME_LEN = 11'd64;
	localparam logic [10:0] FCS_LEN = 11'd4;
	localparam logic [10:0] MAX_FRAME_LEN = 11'd1518;
	// Management transfer length in cycles
	localparam logic [5:0] MGMT_CYCLES = 6'd32;

	typedef enum logic [1:0] {MG_IDLE, MG_RUN, MG_DONE} emc_mgmt_t;
endpackage : emc_pkg

//--- pkg/emc_cfg_if.sv
/*
 Interface carrying the live configuration from the register file to the
 filter and the frame-length helper.
 Assumes one driver (the register side) and read-only consumers.
*/
interface emc_cfg_if;
	logic fullDuplexSelect;
	logic autoFcsAppend;
	logic shortFramePad;
	logic rejectBadFcs;
	logic acceptAllFrames;
	logic acceptMulticast;
	logic [47:0] stationAddr;
	modport src (output fullDuplexSelect, autoFcsAppend, shortFramePad, rejectBadFcs,
		acceptAllFrames, acceptMulticast, stationAddr);
	modport dst (input fullDuplexSelect, autoFcsAppend, shortFramePad, rejectBadFcs,
		acceptAllFrames, acceptMulticast, stationAddr);
endinterface : emc_cfg_if

//--- core/emc_rx_filter.sv
/*
 Receive accept decision for a finished frame.
 Assumes destination and FCS status are stable while frameEnd is high.
*/
module emc_rx_filter
	import emc_pkg::*;
(
	emc_cfg_if.dst cfg,
	input wire logic [47:0] destAddr,
	input wire logic fcsBad,
	input wire logic frameEnd,
	output logic frameKeep,
	output logic frameDrop
);
	logic addrHit;
	logic fcsOk;

	// Station match, multicast group bit, or everything when promiscuous
	always_comb begin
		addrHit = cfg.acceptAllFrames;
		if (destAddr == cfg.stationAddr) addrHit = 1'b1;
		if (cfg.acceptMulticast && destAddr[40]) addrHit = 1'b1;
		fcsOk = !(cfg.rejectBadFcs && fcsBad);
		frameKeep = frameEnd && addrHit && fcsOk;
		frameDrop = frameEnd && !(addrHit && fcsOk);
	end
endmodule : emc_rx_filter

//--- core/emc_tx_len.sv
/*
 Length on the wire of an outgoing frame, after padding and FCS append.
 Assumes payloadLen excludes the FCS.
*/
module emc_tx_len
	import emc_pkg::*;
(
	emc_cfg_if.dst cfg,
	input wire logic [10:0] payloadLen,
	output logic [10:0] wireLen,
	output logic lenBad
);
	logic [10:0] padded;

	// Padding target is the minimum less the FCS the MAC itself appends
	always_comb begin
		padded = payloadLen;
		if (cfg.shortFramePad && payloadLen < MIN_FRAME_LEN - FCS_LEN) padded = MIN_FRAME_LEN - FCS_LEN;
		wireLen = cfg.autoFcsAppend ? padded + FCS_LEN : padded;
		lenBad = (payloadLen == 11'h000) || (wireLen > MAX_FRAME_LEN);
	end
endmodule : emc_tx_len

//--- core/emc_mac_ctrl.sv
/*
 Ethernet MAC control layer: AHB-Lite register file, enable control, receive
 accept path, transmit length check, PHY register access and interrupts.
 Assumes the datapath presents frame events on the same clock.
*/
module emc_mac_ctrl
	import emc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [47:0] rxDestAddr,
	input wire logic rxFcsBad,
	input wire logic rxFrameEnd,
	input wire logic rxPhyErr,
	input wire logic rxFifoPop,
	input wire logic txFifoFull,
	input wire logic [10:0] txPayloadLen,
	input wire logic txFrameStored,
	input wire logic txDone,
	input wire logic txRetryFail,
	input wire logic phyIrqPin,
	input wire logic [15:0] phyRdData,
	output logic phyReq,
	output logic phyWrite,
	output logic [4:0] phyRegAddr,
	output logic [15:0] phyWrData,
	output logic phyAutoNeg,
	output logic txEnable,
	output logic rxEnable,
	output logic fullDuplexSelect,
	output logic [10:0] txWireLen,
	output logic rxFifoFlush,
	output logic rxFrameWrite,
	output logic txCapture,
	output logic rxCapture,
	output logic irq
);
	////////////////////////////////////////////////////////////////////
	emc_cfg_if cfg ();
	logic [2:0] txCtl_r, txCtl_nxt;
	logic [2:0] rxCtl_r, rxCtl_nxt;
	logic tsRoute_r, tsRoute_nxt;
	logic en_r, en_nxt;
	logic [47:0] addr_r, addr_nxt;
	logic [IRQ_W-1:0] irqRaw_r, irqRaw_nxt;
	logic [IRQ_W-1:0] irqEn_r, irqEn_nxt;
	logic [5:0] mgAddr_r, mgAddr_nxt;
	logic [15:0] mgData_r, mgData_nxt;
	logic [5:0] mgCnt_r, mgCnt_nxt;
	emc_mgmt_t mgSt_r, mgSt_nxt;
	logic [7:0] rxCount_r, rxCount_nxt;
	logic [10:0] wireLen_r, wireLen_nxt;
	logic [7:0] aOff_r, aOff_nxt;
	logic aWr_r, aWr_nxt;
	logic aVal_r, aVal_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic phyS1_r, phyS2_r, phyS3_r;
	logic keep, drop, lenBad;
	logic [10:0] lenCalc;
	logic [IRQ_W-1:0] irqEvt;
	logic wrPulse, flushPulse;
	logic [31:0] rdMux;

	// Configuration fanned out to the helpers; read back from the same flops
	assign cfg.fullDuplexSelect = txCtl_r[TX_DUPLEX_BIT];
	assign cfg.autoFcsAppend = txCtl_r[TX_FCS_BIT];
	assign cfg.shortFramePad = txCtl_r[TX_PAD_BIT];
	assign cfg.rejectBadFcs = rxCtl_r[RX_BADFCS_BIT];
	assign cfg.acceptAllFrames = rxCtl_r[RX_PROMISC_BIT];
	assign cfg.acceptMulticast = rxCtl_r[RX_MCAST_BIT];
	assign cfg.stationAddr = addr_r;

	emc_rx_filter uFilter (
		.cfg(cfg),
		.destAddr(rxDestAddr),
		.fcsBad(rxFcsBad),
		.frameEnd(rxFrameEnd && en_r),
		.frameKeep(keep),
		.frameDrop(drop)
	);

	emc_tx_len uLen (
		.cfg(cfg),
		.payloadLen(txPayloadLen),
		.wireLen(lenCalc),
		.lenBad(lenBad)
	);

	////////////////////////////////////////////////////////////////////
	// PHY interrupt pin comes from another domain: two flops, then edge
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			phyS1_r <= 1'b0;
			phyS2_r <= 1'b0;
			phyS3_r <= 1'b0;
		end else begin
			phyS1_r <= phyIrqPin;
			phyS2_r <= phyS1_r;
			phyS3_r <= phyS2_r;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Bus side: one wait-free slave, data phase completes in one cycle
	assign wrPulse = aVal_r && aWr_r;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_r;

	// Read mux; unmapped offsets read as zero
	always_comb begin
		rdMux = 32'h0000_0000;
		case (aOff_nxt)
			OFF_TXCTL: rdMux = {29'h0, txCtl_r};
			OFF_RXCTL: rdMux = {29'h0, rxCtl_r};
			OFF_TSCTL: rdMux = {31'h0, tsRoute_r};
			OFF_ENCTL: rdMux = {31'h0, en_r};
			OFF_ADDRLO: rdMux = addr_r[31:0];
			OFF_ADDRHI: rdMux = {16'h0, addr_r[47:32]};
			OFF_IRQRAW: rdMux = {25'h0, irqRaw_r};
			OFF_IRQEN: rdMux = {25'h0, irqEn_r};
			OFF_MGMT: rdMux = {25'h0, (mgSt_r == MG_RUN), mgAddr_r};
			OFF_MGMTDAT: rdMux = {16'h0, mgData_r};
			OFF_STATUS: rdMux = {29'h0, en_r, (rxCount_r != 8'h00), !txFifoFull};
			default: rdMux = 32'h0000_0000;
		endcase
	end

	// Address-phase capture and register updates
	always_comb begin
		aVal_nxt = hsel && hready && htrans[1];
		aWr_nxt = hwrite;
		aOff_nxt = {haddr[7:2], 2'b00};
		rdata_nxt = (aVal_nxt && !hwrite) ? rdMux : rdata_r;
		txCtl_nxt = txCtl_r;
		rxCtl_nxt = rxCtl_r;
		tsRoute_nxt = tsRoute_r;
		en_nxt = en_r;
		addr_nxt = addr_r;
		irqEn_nxt = irqEn_r;
		flushPulse = 1'b0;
		if (wrPulse) begin
			case (aOff_r)
				OFF_TXCTL: txCtl_nxt = hwdata[2:0];
				OFF_RXCTL: rxCtl_nxt = hwdata[2:0];
				OFF_TSCTL: tsRoute_nxt = hwdata[TS_ROUTE_BIT];
				OFF_ENCTL: begin
					en_nxt = hwdata[EN_BIT];
					flushPulse = 1'b1;
				end
				OFF_ADDRLO: addr_nxt[31:0] = hwdata;
				OFF_ADDRHI: addr_nxt[47:32] = hwdata[15:0];
				OFF_IRQEN: irqEn_nxt = hwdata[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// PHY management transfer: fixed length, then data captured on reads
	always_comb begin
		mgSt_nxt = mgSt_r;
		mgAddr_nxt = mgAddr_r;
		mgData_nxt = mgData_r;
		mgCnt_nxt = mgCnt_r;
		case (mgSt_r)
			MG_IDLE: begin
				if (wrPulse && aOff_r == OFF_MGMTDAT) mgData_nxt = hwdata[15:0];
				if (wrPulse && aOff_r == OFF_MGMT) begin
					mgAddr_nxt = hwdata[5:0];
					mgCnt_nxt = MGMT_CYCLES;
					mgSt_nxt = MG_RUN;
				end
			end
			MG_RUN: begin
				mgCnt_nxt = mgCnt_r - 6'd1;
				if (mgCnt_r == 6'd1) begin
					if (!mgAddr_r[MGMT_WRITE_BIT]) mgData_nxt = phyRdData;
					mgSt_nxt = MG_DONE;
				end
			end
			MG_DONE: mgSt_nxt = MG_IDLE;
			default: mgSt_nxt = MG_IDLE;
		endcase
	end
	assign phyReq = (mgSt_r == MG_RUN);
	assign phyWrite = mgAddr_r[MGMT_WRITE_BIT];
	assign phyRegAddr = mgAddr_r[4:0];
	assign phyWrData = mgData_r;
	assign phyAutoNeg = 1'b1; // PHY runs its own negotiation from reset

	////////////////////////////////////////////////////////////////////
	// Frame count in the receive FIFO; flush wins over traffic
	always_comb begin
		rxCount_nxt = rxCount_r;
		// Saturates when full so an overflow never reads back as an empty FIFO
		if (keep && !(rxFifoPop && rxCount_r != 8'h00) && rxCount_r != 8'hFF) rxCount_nxt = rxCount_r + 8'h01;
		else if (!keep && rxFifoPop && rxCount_r != 8'h00) rxCount_nxt = rxCount_r - 8'd1;
		if (flushPulse) rxCount_nxt = 8'h00;
		wireLen_nxt = txFrameStored ? lenCalc : wireLen_r;
	end

	// Interrupt events; set beats the write-one-to-clear mask
	always_comb begin
		irqEvt = '0;
		irqEvt[IRQ_RX] = keep;
		irqEvt[IRQ_TXER] = txRetryFail || (txFrameStored && lenBad);
		irqEvt[IRQ_TX] = txDone;
		irqEvt[IRQ_RXOF] = keep && (rxCount_r == 8'hFF);
		irqEvt[IRQ_RXER] = rxFrameEnd && en_r && (rxFcsBad || rxPhyErr);
		irqEvt[IRQ_MGMT] = (mgSt_r == MG_DONE);
		irqEvt[IRQ_PHY] = phyS2_r && !phyS3_r;
		irqRaw_nxt = irqRaw_r;
		if (wrPulse && aOff_r == OFF_IRQMSK) irqRaw_nxt = irqRaw_r & ~hwdata[IRQ_W-1:0];
		irqRaw_nxt = irqRaw_nxt | irqEvt;
	end

	////////////////////////////////////////////////////////////////////
	// All state registers other than the PHY interrupt pin flops
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			txCtl_r <= TXCTL_RST;
			rxCtl_r <= RXCTL_RST;
			tsRoute_r <= 1'b0;
			en_r <= 1'b0;
			addr_r <= ADDR_RST;
			irqRaw_r <= IRQ_RST;
			irqEn_r <= IRQ_RST;
			mgAddr_r <= 6'h00;
			mgData_r <= 16'h0000;
			mgCnt_r <= 6'h00;
			mgSt_r <= MG_IDLE;
			rxCount_r <= 8'h00;
			wireLen_r <= 11'h000;
			aOff_r <= 8'h00;
			aWr_r <= 1'b0;
			aVal_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rxFifoFlush <= 1'b0;
			rxFrameWrite <= 1'b0;
			txCapture <= 1'b0;
			rxCapture <= 1'b0;
			irq <= 1'b0;
		end else begin
			txCtl_r <= txCtl_nxt;
			rxCtl_r <= rxCtl_nxt;
			tsRoute_r <= tsRoute_nxt;
			en_r <= en_nxt;
			addr_r <= addr_nxt;
			irqRaw_r <= irqRaw_nxt;
			irqEn_r <= irqEn_nxt;
			mgAddr_r <= mgAddr_nxt;
			mgData_r <= mgData_nxt;
			mgCnt_r <= mgCnt_nxt;
			mgSt_r <= mgSt_nxt;
			rxCount_r <= rxCount_nxt;
			wireLen_r <= wireLen_nxt;
			aOff_r <= aOff_nxt;
			aWr_r <= aWr_nxt;
			aVal_r <= aVal_nxt;
			rdata_r <= rdata_nxt;
			rxFifoFlush <= flushPulse;
			rxFrameWrite <= keep && !drop;
			txCapture <= tsRoute_r && irqRaw_r[IRQ_TX];
			rxCapture <= tsRoute_r && irqRaw_r[IRQ_RX];
			irq <= |(irqRaw_nxt & irqEn_nxt);
		end
	end

	// Transmitter and receiver follow the enable; duplex goes to the MAC
	assign txEnable = en_r;
	assign rxEnable = en_r;
	assign fullDuplexSelect = txCtl_r[TX_DUPLEX_BIT];
	assign txWireLen = wireLen_r;
endmodule : emc_mac_ctrl

//--- dv/emc_mac_ctrl_sva.sv
/*
 Concurrent checks on the ports of the MAC control block.
 Assumes one clock domain, ref_clk, with asynchronous active-low nrst.
*/
module emc_mac_ctrl_sva (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic hresp,
	input wire logic hreadyout,
	input wire logic phyAutoNeg,
	input wire logic txEnable,
	input wire logic rxEnable,
	input wire logic rxFifoFlush,
	input wire logic rxFrameEnd,
	input wire logic rxFrameWrite,
	input wire logic phyReq
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [6:0] reqCnt_r;
	logic [6:0] reqCnt_nxt;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////
	// Length of the running management transfer, cleared when idle
	always_comb begin
		reqCnt_nxt = phyReq ? reqCnt_r + 7'h01 : 7'h00;
	end
	// Registered so the check can look at the whole transfer at its end
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			reqCnt_r <= 7'h00;
		end else begin
			reqCnt_r <= reqCnt_nxt;
		end
	end
	////////////////////////////////////////////////////////////////
	a_resp_okay: assert property (hresp == 1'b0) else $error("bus response not OKAY");
	a_ready_high: assert property (hreadyout == 1'b1) else $error("slave inserted wait state");
	a_autoneg_on: assert property (phyAutoNeg == 1'b1) else $error("auto negotiation off");
	a_enable_pair: assert property (txEnable == rxEnable) else $error("tx and rx enables differ");
	a_flush_pulse: assert property (rxFifoFlush |=> !rxFifoFlush) else $error("flush longer than one cycle");
	a_flush_toggle: assert property ($changed(txEnable) |->
		(rxFifoFlush || $past(rxFifoFlush)) or (##1 rxFifoFlush)) else $error("enable change without flush");
	a_keep_cause: assert property (rxFrameWrite |-> $past(rxFrameEnd) && $past(rxEnable))
		else $error("frame write without frame end");
	a_off_no_keep: assert property (rxFrameEnd && !rxEnable |=> !rxFrameWrite)
		else $error("frame kept while disabled");
	a_mgmt_len: assert property ($fell(phyReq) |-> reqCnt_r == 7'd32) else $error("management length wrong");
endmodule : emc_mac_ctrl_sva

bind emc_mac_ctrl emc_mac_ctrl_sva i_emc_mac_ctrl_sva (.ref_clk(ref_clk), .nrst(nrst), .hresp(hresp),
	.hreadyout(hreadyout), .phyAutoNeg(phyAutoNeg), .txEnable(txEnable), .rxEnable(rxEnable),
	.rxFifoFlush(rxFifoFlush), .rxFrameEnd(rxFrameEnd), .rxFrameWrite(rxFrameWrite), .phyReq(phyReq));

//--- dv/emc_phy_model.sv
/*
 Behavioural PHY: a 32-entry register set behind the management request.
 Assumes the controller holds address and data steady while phyReq is high.
*/
module emc_phy_model (
	input wire logic ref_clk,
	input wire logic phyReq,
	input wire logic phyWrite,
	input wire logic [4:0] phyRegAddr,
	input wire logic [15:0] phyWrData,
	input wire logic irqKick,
	output logic [15:0] phyRdData,
	output logic phyIrqPin
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] regs [32];
	logic [15:0] junk = 16'h5A5A;
	initial foreach (regs[i]) regs[i] = 16'h0000;
	////////////////////////////////////////////////////////////////
	// Register write; the read bus churns when idle so stale data never looks valid
	always @(posedge ref_clk) begin
		if (phyReq && phyWrite) regs[phyRegAddr] <= phyWrData;
		junk <= ~junk;
	end
	assign phyRdData = phyReq ? regs[phyRegAddr] : junk;
	assign phyIrqPin = irqKick;
endmodule : emc_phy_model

//--- dv/ethernet_mac_control_bench.sv
/*
 Self-checking bench for the MAC control block over AHB-Lite.
 Assumes hreadyout feeds back as hready and a PHY model on the management port.
*/
module ethernet_mac_control_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import emc_pkg::*;
	logic ref_clk = 0, nrst = 0, hsel = 0, hwrite = 0, rxFcsBad = 0, rxFrameEnd = 0, rxPhyErr = 0;
	logic rxFifoPop = 0, txFifoFull = 0, txFrameStored = 0, txDone = 0, txRetryFail = 0, irqKick = 0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [47:0] rxDestAddr = 48'h0;
	logic [10:0] txPayloadLen = 11'h0, txWireLen;
	logic [15:0] phyRdData, phyWrData;
	logic [4:0] phyRegAddr;
	logic hready, hreadyout, hresp, phyIrqPin, phyReq, phyWrite, phyAutoNeg, txEnable, rxEnable;
	logic fullDuplexSelect, rxFifoFlush, rxFrameWrite, txCapture, rxCapture, irq;
	int errors = 0, comparisons = 0;
	localparam logic [47:0] STA = 48'h02AA_BBCC_DDEE, MC = 48'h0100_0000_0001, OTH = 48'h0200_0000_0007;
	assign hready = hreadyout;
	always #12.5 ref_clk = ~ref_clk;
	emc_mac_ctrl i_emc_mac_ctrl (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .rxDestAddr(rxDestAddr), .rxFcsBad(rxFcsBad), .rxFrameEnd(rxFrameEnd), .rxPhyErr(rxPhyErr),
		.rxFifoPop(rxFifoPop), .txFifoFull(txFifoFull), .txPayloadLen(txPayloadLen), .txFrameStored(txFrameStored),
		.txDone(txDone), .txRetryFail(txRetryFail), .phyIrqPin(phyIrqPin), .phyRdData(phyRdData), .phyReq(phyReq),
		.phyWrite(phyWrite), .phyRegAddr(phyRegAddr), .phyWrData(phyWrData), .phyAutoNeg(phyAutoNeg),
		.txEnable(txEnable), .rxEnable(rxEnable), .fullDuplexSelect(fullDuplexSelect), .txWireLen(txWireLen),
		.rxFifoFlush(rxFifoFlush), .rxFrameWrite(rxFrameWrite), .txCapture(txCapture), .rxCapture(rxCapture),
		.irq(irq));
	emc_phy_model i_emc_phy_model (.ref_clk(ref_clk), .phyReq(phyReq), .phyWrite(phyWrite), .phyRegAddr(phyRegAddr),
		.phyWrData(phyWrData), .irqKick(irqKick), .phyRdData(phyRdData), .phyIrqPin(phyIrqPin));
	////////////////////////////////////////////////////////////////
	// Compare, verdict and bounded waits
	task chk(string n, logic [31:0] s, logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task report_and_stop;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	task waitRdy;
		int n;
		n = 0;
		@(posedge ref_clk);
		while (hready !== 1'b1) begin
			n++;
			if (n > 40) begin
				errors++;
				report_and_stop;
			end
			@(posedge ref_clk);
		end
	endtask : waitRdy
	// One single transfer; read data taken at the edge that ends the data phase
	task bus(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge ref_clk);
		hsel <= 1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		waitRdy;
		htrans <= 2'h0;
		hwdata <= d;
		waitRdy;
		rd = hrdata;
	endtask : bus
	task rdm(string n, logic [7:0] a, logic [31:0] m, logic [31:0] e);
		bus(0, a, 0);
		chk(n, rd & m, e);
	endtask : rdm
	task poll(logic [7:0] a, int b, logic v);
		int n;
		n = 0;
		bus(0, a, 0);
		while (rd[b] !== v) begin
			n++;
			if (n > 60) begin
				errors++;
				report_and_stop;
			end
			bus(0, a, 0);
		end
	endtask : poll
	////////////////////////////////////////////////////////////////
	// Link events: one received frame, one stored transmit frame, one transmit-done pulse
	task frm(logic [47:0] d, logic bad, logic exp);
		@(posedge ref_clk);
		rxDestAddr <= d;
		rxFcsBad <= bad;
		rxFrameEnd <= 1;
		@(posedge ref_clk);
		rxFrameEnd <= 0;
		#1 chk("frameKeep", rxFrameWrite, exp);
	endtask : frm
	task txf(logic [10:0] l, logic [10:0] e);
		@(posedge ref_clk);
		txPayloadLen <= l;
		txFrameStored <= 1;
		@(posedge ref_clk);
		txFrameStored <= 0;
		#1 chk("wireLen", txWireLen, e);
	endtask : txf
	task pulse_done;
		@(posedge ref_clk);
		txDone <= 1;
		@(posedge ref_clk);
		txDone <= 0;
	endtask : pulse_done
	////////////////////////////////////////////////////////////////
	// Watchdog against a hang anywhere
	initial begin
		repeat (90000) @(posedge ref_clk);
		errors++;
		report_and_stop;
	end
	// Main sequence: reset values, configure, enable, traffic, interrupts, PHY, disable
	initial begin
		repeat (16) @(posedge ref_clk);
		nrst <= 1;
		chk("autoNeg", phyAutoNeg, 1);
		rdm("txctl", OFF_TXCTL, 32'hFFFFFFFF, 0);
		rdm("rxctl", OFF_RXCTL, 32'hFFFFFFFF, 0);
		rdm("irqraw", OFF_IRQRAW, 32'hFFFFFFFF, 0);
		rdm("status", OFF_STATUS, 32'h7, 32'h1);
		bus(1, OFF_TXCTL, 32'h7);
		bus(1, OFF_RXCTL, 32'h1);
		bus(1, OFF_TSCTL, 32'h1);
		bus(1, OFF_ADDRLO, STA[31:0]);
		bus(1, OFF_ADDRHI, {16'h0, STA[47:32]});
		bus(1, OFF_IRQEN, 32'h4);
		bus(1, 8'h40, 32'hFFFFFFFF);
		rdm("txctl", OFF_TXCTL, 32'hFFFFFFFF, 32'h7);
		rdm("tsctl", OFF_TSCTL, 32'hFFFFFFFF, 32'h1);
		rdm("addrlo", OFF_ADDRLO, 32'hFFFFFFFF, STA[31:0]);
		rdm("addrhi", OFF_ADDRHI, 32'hFFFF, STA[47:32]);
		rdm("unmapped", 8'h40, 32'hFFFFFFFF, 0);
		chk("duplex", fullDuplexSelect, 1);
		frm(STA, 0, 0);
		bus(1, OFF_ENCTL, 32'h1);
		#1 chk("enables", {txEnable, rxEnable}, 2'h3);
		frm(STA, 0, 1);
		frm(STA, 1, 0);
		frm(MC, 0, 0);
		frm(OTH, 0, 0);
		rdm("status", OFF_STATUS, 32'h7, 32'h7);
		// Host takes the only stored frame out; packet-available must drop
		@(posedge ref_clk) rxFifoPop <= 1'b1;
		@(posedge ref_clk) rxFifoPop <= 1'b0;
		rdm("popped", OFF_STATUS, 32'h7, 32'h5);
		bus(1, OFF_RXCTL, 32'h7);
		frm(MC, 0, 1);
		frm(OTH, 0, 1);
		frm(OTH, 1, 0);
		rdm("rxErr", OFF_IRQRAW, 32'h11, 32'h11);
		txf(10, 64);
		txf(100, 104);
		bus(1, OFF_TXCTL, 32'h3);
		txf(10, 14);
		bus(1, OFF_TXCTL, 32'h1);
		txf(0, 0);
		rdm("txErr", OFF_IRQRAW, 32'h6, 32'h2);
		chk("irqMasked", irq, 0);
		pulse_done;
		rdm("txDone", OFF_IRQRAW, 32'h4, 32'h4);
		chk("irq", irq, 1);
		chk("capture", {txCapture, rxCapture}, 2'h3);
		bus(1, OFF_IRQMSK, 32'h7F);
		rdm("cleared", OFF_IRQRAW, 32'h7F, 0);
		chk("irqOff", {irq, txCapture}, 2'h0);
		// A PHY-reported error on a good frame still raises the receive error source
		rxPhyErr <= 1'b1;
		frm(STA, 1'b0, 1'b1);
		rxPhyErr <= 1'b0;
		rdm("phyErr", OFF_IRQRAW, 32'h10, 32'h10);
		@(posedge ref_clk) txRetryFail <= 1;
		@(posedge ref_clk) txRetryFail <= 0;
		bus(1, OFF_IRQMSK, 32'h4);
		rdm("partClear", OFF_IRQRAW, 32'h6, 32'h2);
		@(posedge ref_clk) txFifoFull <= 1;
		rdm("noSpace", OFF_STATUS, 32'h1, 0);
		txFifoFull <= 0;
		rxFcsBad <= 1'b0;
		repeat (260) begin
			@(posedge ref_clk) rxFrameEnd <= 1;
			@(posedge ref_clk) rxFrameEnd <= 0;
		end
		rdm("overflow", OFF_IRQRAW, 32'h8, 32'h8);
		bus(1, OFF_MGMTDAT, 32'hC3A5);
		bus(1, OFF_MGMT, 32'h23);
		poll(OFF_MGMT, MGMT_BUSY_BIT, 0);
		bus(1, OFF_MGMTDAT, 32'h0);
		bus(1, OFF_MGMT, 32'h03);
		poll(OFF_MGMT, MGMT_BUSY_BIT, 0);
		rdm("phyRead", OFF_MGMTDAT, 32'hFFFF, 32'hC3A5);
		rdm("mgmtDone", OFF_IRQRAW, 32'h20, 32'h20);
		@(posedge ref_clk) irqKick <= 1;
		poll(OFF_IRQRAW, IRQ_PHY, 1);
		irqKick <= 0;
		bus(1, OFF_ENCTL, 32'h0);
		#1 chk("disabled", {txEnable, rxEnable}, 2'h0);
		rdm("emptied", OFF_STATUS, 32'h6, 0);
		report_and_stop;
	end
endmodule : ethernet_mac_control_bench
